// ### core/boot_script_pkg.sv
// constants and carriers shared by the boot script engine
package boot_script_pkg;

  localparam logic [7:0] OP_EXIT_A      = 8'h00;
  localparam logic [7:0] OP_EXIT_B      = 8'hFF;
  localparam logic [7:0] OP_IDLE        = 8'hAA;
  localparam logic [7:0] OP_WIDE_ON     = 8'hB7;
  localparam logic [7:0] OP_WIDE_OFF    = 8'hE9;
  localparam logic [7:0] OP_STATUS_RD   = 8'h10;
  localparam logic [7:0] OP_COMMAND_WR  = 8'h11;
  localparam logic [7:0] OP_DATA_RD     = 8'h12;
  localparam logic [7:0] OP_DATA_WR     = 8'h13;
  localparam logic [7:0] OP_LOOP_LOAD   = 8'h20;
  localparam logic [7:0] OP_ATTRIBUTE_FETCH_OP_FETCH  = 8'h30;
  localparam logic [7:0] OP_JUMP        = 8'h80;
  localparam logic [7:0] OP_COUNT_DOWN  = 8'h81;

  localparam logic [2:0] LEN_ONE        = 3'h1;
  localparam logic [2:0] LEN_TWO        = 3'h2;
  localparam logic [2:0] LEN_FIVE       = 3'h5;
  localparam logic [31:0] PC_RESET      = 32'h0000_0000;
  localparam logic [7:0]  COUNT_RESET   = 8'h00;

  // host-side port cycle kinds
  typedef enum logic [1:0] {
    PORT_STATUS_RD  = 2'h0,
    PORT_COMMAND_WR = 2'h1,
    PORT_DATA_RD    = 2'h2,
    PORT_DATA_WR    = 2'h3
  } port_kind_e;

  typedef struct packed {
    port_kind_e kind;
    logic [7:0] data;
  } port_req_s;

  // one decoded opcode byte
  typedef struct packed {
    logic       exit_op;
    logic       idle_op;
    logic       wide_addr_on_op;
    logic       wide_addr_off_op;
    logic       status_read_op;
    logic       command_write_op;
    logic       data_read_op;
    logic       data_write_op;
    logic       loop_count_load_op;
    logic       attribute_fetch_op;
    logic       jump_op;
    logic       count_down_branch_op;
    logic       known;
    logic [2:0] len;
  } decode_s;

endpackage

// ### core/opcode_decoder.sv
// combinational decode of one script opcode byte
`timescale 1ns/100ps
module opcode_decoder
  import boot_script_pkg::*;
(
  input  wire logic [7:0] opcode_i,
  output decode_s         dec_o
);

  wire is_exit  = (opcode_i == OP_EXIT_A) || (opcode_i == OP_EXIT_B);
  wire is_idle  = opcode_i == OP_IDLE;
  wire is_won   = opcode_i == OP_WIDE_ON;
  wire is_woff  = opcode_i == OP_WIDE_OFF;
  wire is_sr    = opcode_i == OP_STATUS_RD;
  wire is_cw    = opcode_i == OP_COMMAND_WR;
  wire is_dr    = opcode_i == OP_DATA_RD;
  wire is_dw    = opcode_i == OP_DATA_WR;
  wire is_ll    = opcode_i == OP_LOOP_LOAD;
  wire is_af    = opcode_i == OP_ATTRIBUTE_FETCH_OP_FETCH;
  wire is_jp    = opcode_i == OP_JUMP;
  wire is_cd    = opcode_i == OP_COUNT_DOWN;
  wire one_byte = is_exit | is_idle | is_won | is_woff;
  wire two_byte = is_sr | is_cw | is_dr | is_dw | is_ll | is_af;
  wire five_byte = is_jp | is_cd;

  assign dec_o.exit_op              = is_exit;
  assign dec_o.idle_op              = is_idle;
  assign dec_o.wide_addr_on_op      = is_won;
  assign dec_o.wide_addr_off_op     = is_woff;
  assign dec_o.status_read_op       = is_sr;
  assign dec_o.command_write_op     = is_cw;
  assign dec_o.data_read_op         = is_dr;
  assign dec_o.data_write_op        = is_dw;
  assign dec_o.loop_count_load_op   = is_ll;
  assign dec_o.attribute_fetch_op   = is_af;
  assign dec_o.jump_op              = is_jp;
  assign dec_o.count_down_branch_op = is_cd;
  assign dec_o.known                = one_byte | two_byte | five_byte;
  // unknown codes are stepped over as one byte
  assign dec_o.len = five_byte ? LEN_FIVE :
                     two_byte  ? LEN_TWO  : LEN_ONE;

endmodule

// ### core/boot_display_script_engine.sv
// boot script engine: fetches a program from serial flash and executes it
`timescale 1ns/100ps
// What this block does
// - starts fetching program alone after reset
// - on finish hands controller to host
// - decodes exactly twelve instruction types
// - 00h or FFh ends program, one byte
// - AAh is one-byte no-operation
// - B7h switches flash to four-byte addressing
// - E9h returns flash to normal addressing
// - 10h does host port status read
// - 11h writes operand as port command
// - 12h does data read from port
// - 13h writes operand as port data
// - 20h loads operand into repeat counter
// - 30h fetches attribute named by operand
// - 80h jumps to four-byte target
// - 81h decrements counter, jumps while nonzero
module boot_display_script_engine
  import boot_script_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  // flash byte reader: one request, one answer
  output logic                   flash_req_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic                   flash_wide_addr_o,
  input  wire logic              flash_ack_i,
  input  wire logic [7:0]        flash_data_i,
  // internal host-side port of the controller
  output logic                   port_req_o,
  output port_req_s              port_cmd_o,
  input  wire logic              port_ack_i,
  input  wire logic [7:0]        port_rdata_i,
  // attribute fetch request
  output logic                   attribute_fetch_op_req_o,
  output logic [7:0]             attribute_fetch_op_sel_o,
  input  wire logic              attribute_fetch_op_ack_i,
  // status
  output logic                   running_o,
  output logic                   host_owns_o,
  output logic [7:0]             last_read_o
);

  typedef enum logic [5:0] {
    ST_FETCH   = 6'b000001,
    ST_WAIT_OP = 6'b000010,
    ST_OPERAND = 6'b000100,
    ST_PORT    = 6'b001000,
    ST_ATTRIBUTE_FETCH_OP    = 6'b010000,
    ST_DONE    = 6'b100000
  } state_e;

  state_e            state_q, state_d;
  logic [ADDR_W-1:0] pc_q;
  logic [2:0]        left_q;
  logic [31:0]       target_q;
  logic [7:0]        count_q;
  decode_s           dec;
  decode_s           dec_q;

  //////////////////////////////////////////////////////////////////////////
  // decode

  opcode_decoder u_dec (
    .opcode_i (flash_data_i),
    .dec_o    (dec)
  );

  wire op_byte_in  = (state_q == ST_WAIT_OP) && flash_ack_i;
  wire opd_byte_in = (state_q == ST_OPERAND) && flash_ack_i;
  wire last_opd    = opd_byte_in && (left_q == 3'h1);
  wire [31:0] tgt_full = {target_q[23:0], flash_data_i};
  wire [7:0]  count_dec = count_q - 8'h01;
  wire take_branch = dec_q.jump_op ||
                     (dec_q.count_down_branch_op &&
                      count_dec != 8'h00);
  wire port_op = dec_q.status_read_op | dec_q.command_write_op |
                 dec_q.data_read_op | dec_q.data_write_op;
  wire port_done = (state_q == ST_PORT) && port_ack_i;
  wire attribute_fetch_op_done = (state_q == ST_ATTRIBUTE_FETCH_OP) && attribute_fetch_op_ack_i;

  port_kind_e kind_w;
  assign kind_w = dec_q.status_read_op   ? PORT_STATUS_RD  :
                  dec_q.command_write_op ? PORT_COMMAND_WR :
                  dec_q.data_read_op     ? PORT_DATA_RD    :
                                           PORT_DATA_WR;

  //////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_FETCH:   state_d = ST_WAIT_OP;
      ST_WAIT_OP: begin
        if (flash_ack_i) begin
          if (dec.exit_op)            state_d = ST_DONE;
          else if (dec.len == LEN_ONE) state_d = ST_FETCH;
          else                        state_d = ST_OPERAND;
        end
      end
      ST_OPERAND: begin
        if (last_opd) begin
          if (port_op)                      state_d = ST_PORT;
          else if (dec_q.attribute_fetch_op) state_d = ST_ATTRIBUTE_FETCH_OP;
          else                              state_d = ST_FETCH;
        end
      end
      ST_PORT:    if (port_ack_i) state_d = ST_FETCH;
      ST_ATTRIBUTE_FETCH_OP:    if (attribute_fetch_op_ack_i) state_d = ST_FETCH;
      ST_DONE:    state_d = ST_DONE;
      default:    state_d = ST_DONE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_FETCH;
    end else begin
      state_q <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // program pointer and operands

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_q     <= PC_RESET[ADDR_W-1:0];
      left_q   <= 3'h0;
      target_q <= 32'h0000_0000;
      dec_q    <= '0;
    end else if (op_byte_in) begin
      dec_q  <= dec;
      left_q <= dec.len - LEN_ONE;
      pc_q   <= pc_q + ADDR_W'(1'b1);
      if (dec.len == LEN_ONE) begin
        pc_q <= pc_q + ADDR_W'(1'b1);
      end
    end else if (opd_byte_in) begin
      left_q   <= left_q - 3'h1;
      target_q <= tgt_full;
      if (last_opd) begin
        if (dec_q.len == LEN_FIVE && take_branch) begin
          pc_q <= tgt_full[ADDR_W-1:0];
        end else begin
          pc_q <= pc_q + ADDR_W'(1'b1);
        end
      end else begin
        pc_q <= pc_q + ADDR_W'(1'b1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // counter and addressing mode

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_q           <= COUNT_RESET;
      flash_wide_addr_o <= 1'b0;
    end else begin
      if (op_byte_in && dec.wide_addr_on_op) begin
        flash_wide_addr_o <= 1'b1;
      end
      if (op_byte_in && dec.wide_addr_off_op) begin
        flash_wide_addr_o <= 1'b0;
      end
      if (last_opd && dec_q.loop_count_load_op) begin
        count_q <= flash_data_i;
      end
      if (last_opd && dec_q.count_down_branch_op) begin
        count_q <= count_dec;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outward requests and status

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flash_req_o  <= 1'b0;
      flash_addr_o <= '0;
      port_req_o   <= 1'b0;
      port_cmd_o   <= '0;
      attribute_fetch_op_req_o   <= 1'b0;
      attribute_fetch_op_sel_o   <= 8'h00;
      running_o    <= 1'b1;
      host_owns_o  <= 1'b0;
      last_read_o  <= 8'h00;
    end else begin
      flash_req_o  <= (state_d == ST_WAIT_OP) || (state_d == ST_OPERAND);
      flash_addr_o <= (op_byte_in || opd_byte_in) && !last_opd ?
                      pc_q + ADDR_W'(1'b1) : pc_q;
      if (last_opd && port_op) begin
        port_req_o      <= 1'b1;
        port_cmd_o.kind <= kind_w;
        port_cmd_o.data <= flash_data_i;
      end else if (port_done) begin
        port_req_o <= 1'b0;
      end
      if (port_done && (dec_q.status_read_op || dec_q.data_read_op)) begin
        last_read_o <= port_rdata_i;
      end
      if (last_opd && dec_q.attribute_fetch_op) begin
        attribute_fetch_op_req_o <= 1'b1;
        attribute_fetch_op_sel_o <= flash_data_i;
      end else if (attribute_fetch_op_done) begin
        attribute_fetch_op_req_o <= 1'b0;
      end
      running_o   <= state_d != ST_DONE;
      host_owns_o <= state_d == ST_DONE;
    end
  end

endmodule

// ### verif/boot_script_properties.sv
// boundary assertions for the boot script engine
`timescale 1ns/100ps
module boot_script_properties
  import boot_script_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic              clock_i,
  input wire logic              rst_b_i,
  input wire logic              flash_req_o,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic              flash_wide_addr_o,
  input wire logic              flash_ack_i,
  input wire logic [7:0]        flash_data_i,
  input wire logic              port_req_o,
  input wire port_req_s         port_cmd_o,
  input wire logic              port_ack_i,
  input wire logic [7:0]        port_rdata_i,
  input wire logic              attribute_fetch_op_req_o,
  input wire logic [7:0]        attribute_fetch_op_sel_o,
  input wire logic              attribute_fetch_op_ack_i,
  input wire logic              running_o,
  input wire logic              host_owns_o,
  input wire logic [7:0]        last_read_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  a_start_alone: assert property ($rose(rst_b_i) |-> running_o ##[1:3]
    (flash_req_o && flash_addr_o == '0)) else $error("no fetch at start");
  a_done_quiet: assert property (!running_o |=>
    !running_o && !flash_req_o && !port_req_o && !attribute_fetch_op_req_o)
    else $error("activity after exit");
  a_owner_flip: assert property (host_owns_o != running_o)
    else $error("host ownership not inverse of running");
  a_fetch_hold: assert property (flash_req_o && !flash_ack_i |=>
    flash_req_o && $stable(flash_addr_o)) else $error("fetch dropped");
  a_port_hold: assert property (port_req_o && !port_ack_i |=>
    port_req_o && $stable(port_cmd_o)) else $error("port cycle dropped");
  a_attribute_fetch_op_hold: assert property (attribute_fetch_op_req_o && !attribute_fetch_op_ack_i |=>
    attribute_fetch_op_req_o && $stable(attribute_fetch_op_sel_o)) else $error("attribute dropped");
  a_single_req: assert property (port_req_o |->
    !flash_req_o && !attribute_fetch_op_req_o) else $error("two requests outstanding");
  a_read_capture: assert property (port_req_o && port_ack_i &&
    !port_cmd_o.kind[0] |=> last_read_o == $past(port_rdata_i))
    else $error("read value not kept");

  c_write: cover property (port_ack_i && port_cmd_o.kind == PORT_DATA_WR);
  c_attribute_fetch_op: cover property (attribute_fetch_op_req_o && attribute_fetch_op_ack_i);
  c_exit: cover property ($fell(running_o));
endmodule

bind boot_display_script_engine boot_script_properties #(.ADDR_W(ADDR_W))
  props_u (.*);

// ### verif/script_flash_model.sv
// serial flash model serving boot script bytes
`timescale 1ns/100ps
module script_flash_model (
  input  wire logic        clock_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [7:0]  slow_i,
  output logic             ack_o,
  output logic [7:0]       data_o
);
  logic [7:0] mem [0:255];
  logic [7:0] wait_q = 8'h00;
  initial ack_o = 1'b0;
  initial data_o = 8'h5A;
  // answers after slow_i idle cycles; data toggles while not valid
  always @(posedge clock_i) begin
    if (req_i && !ack_o && wait_q >= slow_i) begin
      ack_o <= 1'b1;
      data_o <= mem[addr_i[7:0]];
      wait_q <= 8'h00;
    end else begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      wait_q <= (req_i && !ack_o) ? wait_q + 8'h01 : 8'h00;
    end
  end
endmodule

// ### verif/boot_display_script_engine_test.sv
// self-checking bench for the boot script engine
`timescale 1ns/100ps
module boot_display_script_engine_test;
  import boot_script_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] arg;
    port_kind_e kind;
  } row_s;
  row_s rows [4] = '{'{OP_STATUS_RD, 8'h61, PORT_STATUS_RD},
    '{OP_COMMAND_WR, 8'h5B, PORT_COMMAND_WR},
    '{OP_DATA_RD, 8'h92, PORT_DATA_RD}, '{OP_DATA_WR, 8'hA7, PORT_DATA_WR}};
  logic        clock_i, rst_b_i, flash_req_o, flash_wide_addr_o, flash_ack_i;
  logic        port_req_o, attribute_fetch_op_req_o;
  logic        port_ack_i = 1'b0;
  logic        attribute_fetch_op_ack_i = 1'b0;
  logic        running_o, host_owns_o;
  logic [31:0] flash_addr_o;
  logic [7:0]  flash_data_i, port_rdata_i, attribute_fetch_op_sel_o, last_read_o, slow_q;
  port_req_s   port_cmd_o;
  logic [10:0] seen_q [$];
  logic [7:0]  attribute_fetch_op_q [$];
  int          mismatches, num_checks;

  boot_display_script_engine dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .flash_req_o(flash_req_o), .flash_addr_o(flash_addr_o),
    .flash_wide_addr_o(flash_wide_addr_o), .flash_ack_i(flash_ack_i),
    .flash_data_i(flash_data_i), .port_req_o(port_req_o),
    .port_cmd_o(port_cmd_o), .port_ack_i(port_ack_i),
    .port_rdata_i(port_rdata_i), .attribute_fetch_op_req_o(attribute_fetch_op_req_o),
    .attribute_fetch_op_sel_o(attribute_fetch_op_sel_o), .attribute_fetch_op_ack_i(attribute_fetch_op_ack_i),
    .running_o(running_o), .host_owns_o(host_owns_o),
    .last_read_o(last_read_o));
  script_flash_model flash_u (.clock_i(clock_i), .req_i(flash_req_o),
    .addr_i(flash_addr_o), .slow_i(slow_q), .ack_o(flash_ack_i),
    .data_o(flash_data_i));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // port and attribute responders, plus a log of completed cycles
  always @(posedge clock_i) begin
    port_ack_i <= port_req_o && !port_ack_i;
    attribute_fetch_op_ack_i <= attribute_fetch_op_req_o && !attribute_fetch_op_ack_i;
    if (port_req_o && port_ack_i) begin
      seen_q.push_back({flash_wide_addr_o, port_cmd_o});
    end
    if (attribute_fetch_op_req_o && attribute_fetch_op_ack_i) begin
      attribute_fetch_op_q.push_back(attribute_fetch_op_sel_o);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // loads a program, resets (twice when cut is set) and waits for exit
  task automatic run(input logic [7:0] p[$], input logic [7:0] slow,
                     input int cut);
    for (int i = 0; i < 256; i++) begin
      flash_u.mem[i] = (i < p.size()) ? p[i] : OP_EXIT_B;
    end
    repeat (2) begin
      @(posedge clock_i);
      rst_b_i <= 1'b0;
      slow_q <= slow;
      repeat (16) @(posedge clock_i);
      check(running_o, 1'b1);
      check(flash_req_o | port_req_o | host_owns_o, 1'b0);
      seen_q.delete();
      attribute_fetch_op_q.delete();
      rst_b_i <= 1'b1;
      if (cut == 0) break;
      repeat (cut) @(posedge clock_i);
      cut = 0;
    end
    for (int n = 0; n < 4000 && host_owns_o !== 1'b1; n++) begin
      @(posedge clock_i);
      #1;
    end
    check(host_owns_o, 1'b1);
    check(running_o, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
  initial begin
    rst_b_i = 1'b0;
    port_rdata_i = 8'h00;
    slow_q = 8'h00;
    mismatches = 0;
    num_checks = 0;
    foreach (rows[r]) begin
      @(posedge clock_i);
      // read data differs from the operand so the two cannot be confused
      port_rdata_i <= ~rows[r].arg;
      run('{rows[r].op, rows[r].arg, OP_IDLE, OP_EXIT_A}, 8'h00, 0);
      check(seen_q.size(), 1);
      check(seen_q[0][9:8], rows[r].kind);
      if (rows[r].kind[0]) begin
        check(seen_q[0][7:0], rows[r].arg);
      end else begin
        check(last_read_o, port_rdata_i);
      end
    end
    run('{OP_LOOP_LOAD, 8'h03, OP_DATA_WR, 8'h77, OP_COUNT_DOWN, 8'h00,
          8'h00, 8'h00, 8'h02, OP_EXIT_B}, 8'h02, 0);
    check(seen_q.size(), 3);
    run('{OP_JUMP, 8'h00, 8'h00, 8'h00, 8'h07, OP_DATA_WR, 8'h11,
          OP_COMMAND_WR, 8'h22, OP_EXIT_A}, 8'h00, 0);
    check(seen_q.size(), 1);
    check(seen_q[0], {1'b0, PORT_COMMAND_WR, 8'h22});
    run('{OP_WIDE_ON, OP_DATA_WR, 8'h01, OP_WIDE_OFF, OP_ATTRIBUTE_FETCH_OP_FETCH,
          8'h4D, 8'h5F, OP_COMMAND_WR, 8'h02, OP_EXIT_A}, 8'h03, 0);
    check(seen_q[0], {1'b1, PORT_DATA_WR, 8'h01});
    check(seen_q[1], {1'b0, PORT_COMMAND_WR, 8'h02});
    check(attribute_fetch_op_q.size() == 1 ? attribute_fetch_op_q[0] : 8'h00, 8'h4D);
    run('{OP_LOOP_LOAD, 8'h03, OP_DATA_WR, 8'h77, OP_COUNT_DOWN, 8'h00,
          8'h00, 8'h00, 8'h02, OP_EXIT_B}, 8'h00, 8);
    check(seen_q.size(), 3);
    test_done();
  end
endmodule
